/* dlpd_display.sv */
// Diagnostic LED page display with page stepping, wakeup inputs and pulse counters
//
// What this block does
// - Output page: output indicator, LEDs follow outputs 1-8
// - Output page: LEDs 9, 10 show wetting switches
// - Input, output, analog input pages: processor indicator flashes on bad config
// - Analog input page: four LEDs per input, ordered
// - Uncalibrated input also lights overflow and underflow
// - Type LED off for current, on for voltage
// - Analog output page: voltage, current, uncalibrated LEDs
// - User page: masked LEDs follow application values
// - Button or command leaves user page to processor
// - Test page: masked LEDs follow test utility
// - Inputs 1 to 3 can raise wakeup events
// - Two inputs count rising edges, report state
// - Each press advances page, wraps to processor
// - Press while dark only turns display on
`timescale 1ns/1ps
module dlpd_display #(
  parameter int unsigned FLASH_CYC = dlpd_pkg::FLASH_HALF_CYC,
  parameter int unsigned DEB_CYC   = dlpd_pkg::DEBOUNCE_CYC,
  parameter int unsigned CNT_W     = dlpd_pkg::COUNT_W
) (
  // Clock and reset
  input  wire logic                    sys_clk_in,
  input  wire logic                    rst_in,
  // Push-button and page control
  input  wire logic                    button_in,
  input  wire logic                    display_off_in,
  input  wire logic                    user_exit_cmd_in,
  input  wire logic                    test_select_in,
  // Status shown on the pages
  input  wire logic                    cfg_loaded_in,
  input  wire logic                    bootstrap_in,
  input  wire logic [15:0]             cpu_page_leds_in,
  input  wire logic [15:0]             di_page_leds_in,
  input  wire logic [7:0]              discrete_outputs_in,
  input  wire logic                    wetting_switch_one_in,
  input  wire logic                    wetting_switch_two_in,
  input  wire dlpd_pkg::dlpd_ai_t [3:0] analog_inputs_in,
  input  wire dlpd_pkg::dlpd_ao_t      analog_output_one_in,
  input  wire logic [15:0]             user_leds_in,
  input  wire logic [15:0]             test_leds_in,
  // Wakeup and pulse counting pins
  input  wire logic [2:0]              wakeup_inputs_in,
  input  wire logic [2:0]              wakeup_enable_in,
  input  wire logic                    pulse_count_input_a_in,
  input  wire logic                    pulse_count_input_b_in,
  // Panel
  output dlpd_pkg::dlpd_top_t          top_row_out,
  output logic [15:0]                  panel_leds_out,
  output logic                         display_on_out,
  output dlpd_pkg::dlpd_page_t         page_out,
  // Wakeup and counters
  output logic [2:0]                   wakeup_out,
  output logic [1:0]                   pulse_state_out,
  output logic [CNT_W-1:0]             pulse_count_a_out,
  output logic [CNT_W-1:0]             pulse_count_b_out
);
  import dlpd_pkg::*;

  localparam int unsigned FW = $clog2(FLASH_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic dlpd_page_t next_page_of(input dlpd_page_t p);
    unique case (p)
      PG_CPU:  next_page_of = PG_DI;
      PG_DI:   next_page_of = PG_DO;
      PG_DO:   next_page_of = PG_AI;
      PG_AI:   next_page_of = PG_AO;
      PG_AO:   next_page_of = PG_USER;
      PG_USER: next_page_of = PG_TEST;
      PG_TEST: next_page_of = PG_CPU;
      default: next_page_of = PG_CPU;
    endcase
  endfunction : next_page_of

  // Uncalibrated is shown as both limit LEDs lit
  function automatic logic [3:0] ai_leds(input dlpd_ai_t a);
    ai_leds = {a.voltage, a.uncal, a.underflow | a.uncal, a.overflow | a.uncal};
  endfunction : ai_leds

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: config, wakeup x3, pulse x2

  logic [5:0] sync1;
  logic [5:0] sync2;
  logic [5:0] prev;
  logic       cfg_ok;
  logic [2:0] wake_s;
  logic [1:0] pulse_s;

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1 <= 6'h01;
      sync2 <= 6'h01;
      prev  <= 6'h01;
    end else begin
      sync1 <= {pulse_count_input_b_in, pulse_count_input_a_in, wakeup_inputs_in, cfg_loaded_in};
      sync2 <= sync1;
      prev  <= sync2;
    end
  end

  assign cfg_ok  = sync2[0];
  assign wake_s  = sync2[3:1];
  assign pulse_s = sync2[5:4];

  ////////////////////////////////////////////////////////////////////////////
  // Button

  logic press;

  dlpd_button #(
    .DEB_CYC (DEB_CYC)
  ) u_button (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .button_in  (button_in),
    .press_out  (press),
    .level_out  ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Page selector

  logic       display_on;
  dlpd_page_t page;
  logic       next_display_on;
  dlpd_page_t next_page;

  // Auto-off wins over a press in the same cycle
  always_comb begin
    next_display_on = display_on;
    next_page       = page;
    if (display_off_in) begin
      next_display_on = 1'h0;
    end else if (press) begin
      if (!display_on) begin
        next_display_on = 1'h1;
      end else if (page == PG_USER) begin
        next_page = PG_CPU;
      end else begin
        next_page = next_page_of(page);
      end
    end else if (display_on && page == PG_USER && user_exit_cmd_in) begin
      next_page = PG_CPU;
    end else if (display_on && test_select_in) begin
      next_page = PG_TEST;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      display_on <= DISPLAY_ON_RESET;
      page       <= PAGE_RESET;
    end else begin
      display_on <= next_display_on;
      page       <= next_page;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flash divider

  logic [FW-1:0] flash_cnt;
  logic          flash_phase;
  logic [FW-1:0] next_flash_cnt;
  logic          next_flash_phase;

  always_comb begin
    next_flash_cnt   = flash_cnt + 1'h1;
    next_flash_phase = flash_phase;
    if (flash_cnt == FW'(FLASH_CYC - 1)) begin
      next_flash_cnt   = '0;
      next_flash_phase = ~flash_phase;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      flash_cnt   <= '0;
      flash_phase <= 1'h0;
    end else begin
      flash_cnt   <= next_flash_cnt;
      flash_phase <= next_flash_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Panel drive

  dlpd_top_t   top;
  logic [15:0] panel;
  dlpd_top_t   next_top;
  logic [15:0] next_panel;

  always_comb begin
    next_top   = '0;
    next_panel = '0;
    if (display_on) begin
      unique case (page)
        PG_CPU: begin
          next_top.cpu_indicator = (bootstrap_in || !cfg_ok) ? flash_phase : 1'h1;
          next_panel             = cpu_page_leds_in;
        end
        PG_DI: begin
          next_top.cpu_indicator        = !cfg_ok && flash_phase;
          next_top.input_page_indicator = 1'h1;
          next_panel                    = di_page_leds_in;
        end
        PG_DO: begin
          next_top.cpu_indicator         = !cfg_ok && flash_phase;
          next_top.output_page_indicator = 1'h1;
          next_panel[7:0]                = discrete_outputs_in;
          next_panel[8]                  = wetting_switch_one_in;
          next_panel[9]                  = wetting_switch_two_in;
        end
        PG_AI: begin
          next_top.cpu_indicator         = !cfg_ok && flash_phase;
          next_top.analog_page_indicator = 1'h1;
          for (int i = 0; i < AI_N; i++) begin
            next_panel[4*i +: 4] = ai_leds(analog_inputs_in[i]);
          end
        end
        PG_AO: begin
          next_top.cpu_indicator        = 1'h1;
          next_top.input_page_indicator = 1'h1;
          next_panel[2:0]               = analog_output_one_in;
        end
        PG_USER: begin
          next_top.cpu_indicator         = 1'h1;
          next_top.output_page_indicator = 1'h1;
          next_panel                     = user_leds_in & USER_MASK;
        end
        PG_TEST: begin
          next_top.cpu_indicator         = 1'h1;
          next_top.analog_page_indicator = 1'h1;
          next_panel                     = test_leds_in & TEST_MASK;
        end
        default: begin
          next_top   = '0;
          next_panel = '0;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      top   <= '0;
      panel <= '0;
    end else begin
      top   <= next_top;
      panel <= next_panel;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wakeup events and pulse counters

  logic [2:0]       wake;
  logic [CNT_W-1:0] cnt_a;
  logic [CNT_W-1:0] cnt_b;
  logic [2:0]       next_wake;
  logic [CNT_W-1:0] next_cnt_a;
  logic [CNT_W-1:0] next_cnt_b;

  // Counters wrap; software takes differences between reads
  always_comb begin
    next_wake  = wake_s & ~prev[3:1] & wakeup_enable_in;
    next_cnt_a = cnt_a;
    next_cnt_b = cnt_b;
    if (pulse_s[0] && !prev[4]) begin
      next_cnt_a = cnt_a + 1'h1;
    end
    if (pulse_s[1] && !prev[5]) begin
      next_cnt_b = cnt_b + 1'h1;
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      wake  <= 3'h0;
      cnt_a <= '0;
      cnt_b <= '0;
    end else begin
      wake  <= next_wake;
      cnt_a <= next_cnt_a;
      cnt_b <= next_cnt_b;
    end
  end

  assign top_row_out       = top;
  assign panel_leds_out    = panel;
  assign display_on_out    = display_on;
  assign page_out          = page;
  assign wakeup_out        = wake;
  assign pulse_state_out   = prev[5:4];
  assign pulse_count_a_out = cnt_a;
  assign pulse_count_b_out = cnt_b;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  a_do_page_leds: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $past(display_on) && $past(page) == PG_DO |->
      panel[7:0] == $past(discrete_outputs_in) && top[2:0] == 3'h2)
    else $error("output page LEDs wrong");

  a_wet_switch_leds: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $past(display_on) && $past(page) == PG_DO |->
      panel[9:8] == {$past(wetting_switch_two_in), $past(wetting_switch_one_in)} && panel[15:10] == 6'h00)
    else $error("wetting switch LEDs wrong");

  a_cpu_fault_flash: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $past(display_on) && ($past(page) == PG_DI || $past(page) == PG_DO || $past(page) == PG_AI) |->
      top.cpu_indicator == (!$past(cfg_ok) && $past(flash_phase)))
    else $error("processor indicator flash wrong");

  a_ai_page_flags: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $past(display_on) && $past(page) == PG_AI |->
      top[2:0] == 3'h1 && panel[12] == ($past(analog_inputs_in[3].overflow) || $past(analog_inputs_in[3].uncal)))
    else $error("analog input page wrong");

  a_ai_uncal_both: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $past(display_on) && $past(page) == PG_AI && $past(analog_inputs_in[1].uncal) |->
      panel[6:4] == 3'h7)
    else $error("uncalibrated input not shown as both limits");

  a_ai_type_led: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $past(display_on) && $past(page) == PG_AI |->
      panel[3] == $past(analog_inputs_in[0].voltage) && panel[15] == $past(analog_inputs_in[3].voltage))
    else $error("measurement type LED wrong");

  a_ao_page_leds: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $past(display_on) && $past(page) == PG_AO |->
      top == 4'hC && panel[15:3] == 13'h0000 && panel[1] == $past(analog_output_one_in.current))
    else $error("analog output page wrong");

  a_user_page_mask: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $past(display_on) && $past(page) == PG_USER |->
      top == 4'hA && panel == ($past(user_leds_in) & USER_MASK))
    else $error("user page wrong");

  a_user_exit_cmd: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    display_on && page == PG_USER && (press || user_exit_cmd_in) && !display_off_in |=>
      page == PG_CPU ##1 (top.cpu_indicator || !$past(cfg_ok) || $past(bootstrap_in)))
    else $error("user page not left to processor page");

  a_test_page_mask: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $past(display_on) && $past(page) == PG_TEST |->
      top == 4'h9 && panel == ($past(test_leds_in) & TEST_MASK))
    else $error("test page wrong");

  a_wakeup_event: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $rose(wake_s[2]) && wakeup_enable_in[2] |=> wakeup_out[2] ##1 !wakeup_out[2])
    else $error("wakeup event missed or stretched");

  a_pulse_count: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $rose(pulse_s[0]) |=> pulse_count_a_out == $past(pulse_count_a_out) + 1'h1 && pulse_state_out[0])
    else $error("pulse count not advanced");

  a_press_advance: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    display_on && press && !display_off_in && page == PG_DO |=> page == PG_AI)
    else $error("press did not advance page");

  a_first_press_on: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    !display_on && press && !display_off_in |=> display_on && page == $past(page))
    else $error("first press changed page");

endmodule : dlpd_display

/* dlpd_pkg.sv */
// Package for the diagnostic LED page display: constants, page codes and carriers
package dlpd_pkg;

  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CLK_PER_MS      = CLK_HZ / 1000;

  // Half period of the fault flash, in ms and in cycles
  localparam int unsigned FLASH_HALF_MS   = 250;
  localparam int unsigned FLASH_HALF_CYC  = FLASH_HALF_MS * CLK_PER_MS;

  // Push-button must be stable this long to count
  localparam int unsigned DEBOUNCE_MS     = 20;
  localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_MS * CLK_PER_MS;

  localparam int unsigned COUNT_W         = 16;
  localparam int unsigned PANEL_N         = 16;
  localparam int unsigned AI_N            = 4;
  localparam int unsigned WAKE_N          = 3;

  // Panel LEDs the application and the test utility may drive
  localparam logic [15:0] USER_MASK       = 16'hF777;
  localparam logic [15:0] TEST_MASK       = 16'h7777;

  // Page codes, Gray along next_page_of from PG_CPU to PG_TEST; the steps back to PG_CPU are not
  typedef enum logic [2:0] {
    PG_CPU  = 3'h0,
    PG_DI   = 3'h1,
    PG_DO   = 3'h3,
    PG_AI   = 3'h2,
    PG_AO   = 3'h6,
    PG_USER = 3'h7,
    PG_TEST = 3'h5
  } dlpd_page_t;

  localparam dlpd_page_t PAGE_RESET       = PG_CPU;
  localparam logic       DISPLAY_ON_RESET = 1'h0;

  // One analog input's status flags
  typedef struct packed {
    logic voltage;
    logic uncal;
    logic underflow;
    logic overflow;
  } dlpd_ai_t;

  // Analog output status flags
  typedef struct packed {
    logic uncal;
    logic current;
    logic voltage;
  } dlpd_ao_t;

  // Top indicator row
  typedef struct packed {
    logic cpu_indicator;
    logic input_page_indicator;
    logic output_page_indicator;
    logic analog_page_indicator;
  } dlpd_top_t;

endpackage : dlpd_pkg

/* dlpd_button.sv */
// Push-button synchroniser and debouncer giving one pulse per press
`timescale 1ns/1ps
module dlpd_button #(
  parameter int unsigned DEB_CYC = dlpd_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic sys_clk_in,
  input  wire logic rst_in,
  // Raw pin
  input  wire logic button_in,
  // Debounced result
  output logic      press_out,
  output logic      level_out
);
  import dlpd_pkg::*;

  localparam int unsigned DW = $clog2(DEB_CYC + 1);

  logic          sync1;
  logic          sync2;
  logic          stable;
  logic [DW-1:0] cnt;
  logic          press;
  logic          next_stable;
  logic [DW-1:0] next_cnt;
  logic          next_press;

  // Change accepted only after a full quiet interval
  always_comb begin
    next_stable = stable;
    next_cnt    = '0;
    next_press  = 1'h0;
    if (sync2 != stable) begin
      if (cnt == DW'(DEB_CYC - 1)) begin
        next_stable = sync2;
        next_press  = sync2;
      end else begin
        next_cnt = cnt + 1'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync1  <= 1'h0;
      sync2  <= 1'h0;
      stable <= 1'h0;
      cnt    <= '0;
      press  <= 1'h0;
    end else begin
      sync1  <= button_in;
      sync2  <= sync1;
      stable <= next_stable;
      cnt    <= next_cnt;
      press  <= next_press;
    end
  end

  assign press_out = press;
  assign level_out = stable;

endmodule : dlpd_button

/* dlpd_panel_model.sv */
// Front panel push-button model with optional contact bounce
`timescale 1ns/1ps
module dlpd_panel_model #(
  parameter int unsigned HOLD_CYC = 10
) (
  // Clock
  input  wire logic sys_clk_in,
  // Press request from the bench
  input  wire logic press_req_in,
  input  wire logic bounce_in,
  // Button pin
  output logic      button_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Contacts chatter with one-cycle glitches, shorter than any sane debounce
  always begin
    button_out = 1'h0;
    @(posedge press_req_in);
    @(posedge sys_clk_in);
    #10;
    if (bounce_in) begin
      repeat (2) begin
        button_out = 1'h1;
        @(posedge sys_clk_in);
        #10;
        button_out = 1'h0;
        @(posedge sys_clk_in);
        #10;
      end
    end
    button_out = 1'h1;
    repeat (HOLD_CYC) @(posedge sys_clk_in);
    #10;
  end
endmodule : dlpd_panel_model

/* test_dlpd_display.sv */
// Self-checking testbench for the diagnostic LED page display
`timescale 1ns/1ps
module test_dlpd_display;
  import dlpd_pkg::*;

  logic sys_clk = 1'h0, rst = 1'h1, button, press_req = 1'h0, bounce = 1'h0;
  logic display_off = 1'h0, user_exit = 1'h0, test_sel = 1'h0, cfg_ok = 1'h1;
  logic [15:0] cpu_leds = 16'h5A5A, di_leds = 16'hC3C3, user_leds = 16'hFFFF, test_leds = 16'hFFFF;
  logic [7:0]  dout = 8'hA5;
  logic        ws1 = 1'h1, ws2 = 1'h0, pa = 1'h0, pb = 1'h0;
  logic [2:0]  wake = 3'h0, wake_en = 3'h5, wake_seen;
  dlpd_ai_t [3:0] ai = '0;
  dlpd_ao_t    ao = '0;
  dlpd_top_t   top;
  logic [15:0] panel, cnt_a, cnt_b;
  logic        disp_on;
  dlpd_page_t  page;
  logic [2:0]  wake_out;
  logic [1:0]  pstate, seen;
  int          failures = 0, checks_done = 0, n;

  always #50 sys_clk = ~sys_clk;

  dlpd_display #(.FLASH_CYC(4), .DEB_CYC(3), .CNT_W(16)) dlpd_display_i (
    .sys_clk_in(sys_clk), .rst_in(rst), .button_in(button), .display_off_in(display_off),
    .user_exit_cmd_in(user_exit), .test_select_in(test_sel), .cfg_loaded_in(cfg_ok),
    .bootstrap_in(1'h0), .cpu_page_leds_in(cpu_leds), .di_page_leds_in(di_leds),
    .discrete_outputs_in(dout), .wetting_switch_one_in(ws1), .wetting_switch_two_in(ws2),
    .analog_inputs_in(ai), .analog_output_one_in(ao), .user_leds_in(user_leds),
    .test_leds_in(test_leds), .wakeup_inputs_in(wake), .wakeup_enable_in(wake_en),
    .pulse_count_input_a_in(pa), .pulse_count_input_b_in(pb), .top_row_out(top),
    .panel_leds_out(panel), .display_on_out(disp_on), .page_out(page), .wakeup_out(wake_out),
    .pulse_state_out(pstate), .pulse_count_a_out(cnt_a), .pulse_count_b_out(cnt_b));

  dlpd_panel_model #(.HOLD_CYC(10)) dlpd_panel_model_i (
    .sys_clk_in(sys_clk), .press_req_in(press_req), .bounce_in(bounce), .button_out(button));

  ////////////////////////////////////////////////////////////////////////////
  task automatic results;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen_v, input logic [31:0] exp_v);
    checks_done++;
    if (seen_v !== exp_v) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen_v, exp_v);
    end
  endtask : check

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #10;
  endtask : cyc

  task automatic pulse(ref logic s);
    s = 1'h1;
    cyc(1);
    s = 1'h0;
    cyc(3);
  endtask : pulse

  // Waits for the display state to move, then lets the release settle
  task automatic press(input logic b);
    logic [3:0] st;
    int         k;
    st = {disp_on, page};
    k = 0;
    bounce = b;
    press_req = 1'h1;
    cyc(1);
    press_req = 1'h0;
    while ({disp_on, page} === st && k < 60) begin
      cyc(1);
      k++;
    end
    if (k >= 60) begin
      failures++;
      results();
    end
    cyc(16);
  endtask : press

  function automatic logic [15:0] ai_exp(input dlpd_ai_t [3:0] a);
    logic [15:0] r;
    for (int i = 0; i < 4; i++) begin
      r[4*i +: 4] = {a[i].voltage, a[i].uncal, a[i].underflow | a[i].uncal, a[i].overflow | a[i].uncal};
    end
    return r;
  endfunction : ai_exp

  // Collects whether the processor indicator was seen lit and dark
  task automatic flash_watch(output logic [1:0] s);
    s = 2'h0;
    repeat (16) begin
      cyc(1);
      s = s | {top.cpu_indicator === 1'h1, top.cpu_indicator === 1'h0};
    end
  endtask : flash_watch

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    cyc(8);
    rst = 1'h0;
    cyc(2);
    check(disp_on, 1'h0);
    check(page, PG_CPU);
    check({top, panel}, 20'h0);
    press(1'h0);
    check({disp_on, page}, {1'h1, PG_CPU});
    check({top, panel}, 20'h85A5A);
    press(1'h1);
    check(page, PG_DI);
    check({top, panel}, 20'h4C3C3);
    press(1'h0);
    check(page, PG_DO);
    check({top, panel}, 20'h201A5);
    {ws1, ws2, dout} = {2'h1, 8'h5A};
    cyc(2);
    check(panel, 16'h025A);
    flash_watch(seen);
    check(seen, 2'h1);
    cfg_ok = 1'h0;
    cyc(4);
    flash_watch(seen);
    check(seen, 2'h3);
    cfg_ok = 1'h1;
    press(1'h0);
    check({page, top}, {PG_AI, 4'h1});
    for (int v = 0; v < 16; v++) begin
      for (int i = 0; i < 4; i++) ai[i] = 4'(v + 5 * i);
      cyc(2);
      check(panel, ai_exp(ai));
    end
    press(1'h0);
    check({page, top}, {PG_AO, 4'hC});
    for (int v = 0; v < 8; v++) begin
      ao = 3'(v);
      cyc(2);
      check(panel, {13'h0, ao});
    end
    press(1'h0);
    check({page, top, panel}, {PG_USER, 4'hA, 16'hF777});
    user_leds = 16'h9ABC;
    cyc(2);
    check(panel, 16'h9234);
    pulse(user_exit);
    check(page, PG_CPU);
    pulse(test_sel);
    check({page, top, panel}, {PG_TEST, 4'h9, 16'h7777});
    pulse(user_exit);
    check(page, PG_TEST);
    press(1'h0);
    check(page, PG_CPU);
    for (int i = 0; i < 5; i++) press(1'h0);
    check(page, PG_USER);
    press(1'h0);
    check(page, PG_CPU);
    pulse(display_off);
    check({disp_on, top, panel}, 21'h0);
    pulse(test_sel);
    check({disp_on, page}, {1'h0, PG_CPU});
    press(1'h0);
    check({disp_on, page}, {1'h1, PG_CPU});
    // Wakeup: only enabled inputs pulse, each once
    for (int r = 0; r < 2; r++) begin
      wake_seen = 3'h0;
      n = 0;
      wake = r ? 3'h2 : 3'h7;
      repeat (8) begin
        cyc(1);
        wake_seen = wake_seen | wake_out;
        n += (wake_out !== 3'h0);
      end
      check({n[3:0], wake_seen}, {4'h1, r ? 3'h2 : 3'h5});
      wake = 3'h0;
      wake_en = 3'h2;
      cyc(4);
    end
    for (int i = 0; i < 5; i++) begin
      {pa, pb} = {1'h1, i < 2};
      cyc(3);
      check(pstate[0], 1'h1);
      {pa, pb} = 2'h0;
      cyc(3);
    end
    cyc(2);
    check({cnt_a, cnt_b}, {16'h0005, 16'h0002});
    pa = 1'h1;
    cyc(4);
    check({pstate, cnt_a}, {2'h1, 16'h0006});
    results();
  end
endmodule : test_dlpd_display
